// [design/pbm_pkg.sv]
// Package for the port B pin function multiplexer
package pbm_pkg;

    localparam int PBM_PINS = 6;
    localparam int PBM_ANA_PINS = 5;

    // Pin indices
    localparam int PBM_PIN_IRQ0 = 0;
    localparam int PBM_PIN_IRQ1 = 1;
    localparam int PBM_PIN_IRQ2 = 2;
    localparam int PBM_PIN_FAULT = 0;
    localparam int PBM_PIN_EPWM_B = 2;
    localparam int PBM_PIN_EPWM_C = 1;
    localparam int PBM_PIN_EPWM_D = 4;
    localparam int PBM_PIN_CAPCMP = 3;
    localparam int PBM_PIN_CMP_CH2 = 3;
    localparam int PBM_PIN_CMP_CH3 = 1;
    localparam int PBM_PIN_PROG = 5;

    // Register offsets
    localparam logic [3:0] ADDR_LATCH = 4'h0;
    localparam logic [3:0] ADDR_DIR = 4'h1;
    localparam logic [3:0] ADDR_ANSEL = 4'h2;
    localparam logic [3:0] ADDR_PULLUP = 4'h3;
    localparam logic [3:0] ADDR_PORT = 4'h4;
    localparam logic [3:0] ADDR_CFG = 4'h5;

    // Values after reset
    localparam logic [5:0] PBM_DIR_RST = 6'h3F;
    localparam logic [5:0] PBM_LATCH_RST = 6'h00;
    localparam logic [4:0] PBM_ANA_ON = 5'h1F;
    localparam logic [4:0] PBM_ANA_OFF = 5'h00;
    localparam logic PBM_CAPCMP_CH2_SEL_RST = 1'b1;
    localparam logic PBM_CAPCMP_CH2_ON_PIN3 = 1'b0;
    localparam logic PBM_DIR_OUT = 1'b0;
    localparam logic PBM_DIR_IN = 1'b1;

    // Configuration sampled at reset
    typedef struct packed {
        logic capcmp_ch2_pin_select;
        logic analog_default_config;
        logic low_voltage_prog_enable;
        logic package_28pin;
    } pbm_cfg_t;

    // Enhanced PWM outputs
    typedef struct packed {
        logic epwm_out_b;
        logic epwm_out_c;
        logic epwm_out_d;
    } pbm_epwm_t;

    // Pin drive
    typedef struct packed {
        logic [5:0] out;
        logic [5:0] oe;
        logic [5:0] pullup_on;
    } pbm_pad_t;

endpackage

// [design/pbm_sync.sv]
// Two-flop synchroniser bank for pin inputs
`timescale 1ns/100ps
`default_nettype none
module pbm_sync
    import pbm_pkg::*;
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic reset_i,
    // Data
    input wire logic [PBM_PINS-1:0] async_i,
    output logic [PBM_PINS-1:0] sync_o
);
    logic [PBM_PINS-1:0] meta_r;
    logic [PBM_PINS-1:0] meta_nxt;
    logic [PBM_PINS-1:0] sync_r;
    logic [PBM_PINS-1:0] sync_nxt;

    always_comb begin
        meta_nxt = async_i;
        sync_nxt = meta_r;
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            meta_r <= '0;
            sync_r <= '0;
        end else begin
            meta_r <= meta_nxt;
            sync_r <= sync_nxt;
        end
    end

    assign sync_o = sync_r;
endmodule // pbm_sync
`default_nettype wire

// [design/pbm_mux.sv]
// Port B pins 0 to 5 function multiplexer
// Notes on behaviour
// - Capture/compare channel 2 uses port B pin 3 when its select bit is 0, else port C pin 1 (default 1).
// - With direction 0 a pin is driven from its latch bit, even when analog is selected.
// - With direction 1 the pin level is data input with optional pull-up, both off while analog is selected.
// - At reset pins 0 to 4 start analog when the analog default bit is set, digital otherwise.
// - On pin 3 channel 2 drives compare/PWM output at direction 0 or while it is an output, and takes capture input at direction 1 otherwise.
// - Pins 0, 1 and 2 feed external interrupt inputs 0, 1 and 2 when their direction bit is 1.
// - Pin 0 feeds the PWM fault input only when software enables it and direction is 1.
// - On the 28-pin package PWM outputs B, C and D drive pins 2, 1 and 4 when direction is 0.
// - Pins 0 to 4 connect to ADC channels 12, 10, 8, 9 and 11 when analog and direction 1.
// - Pins 3 and 1 feed the comparator inverting input channels 2 and 3 under the ADC analog select.
// - With low-voltage programming enabled pin 5 is only the programming entry input.
// - While serial programming or debug is on, only the pin 5 output driver is disabled; other pin functions stay on.
// - Direction-independent functions override the direction bit and set the pin direction themselves.
// - A pin's pull-up is off whenever the pin is an output, whatever its enable says.
`timescale 1ns/100ps
`default_nettype none
module pbm_mux
    import pbm_pkg::*;
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic reset_i,
    // Configuration bits, sampled at reset
    input wire pbm_cfg_t cfg_i,
    // Debug or serial programming active on pins 6 and 7
    input wire logic prog_debug_active_i,
    // Register bus
    input wire logic [3:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [7:0] rdata_o,
    // Pins
    input wire logic [PBM_PINS-1:0] pin_i,
    output pbm_pad_t pad_o,
    output logic [PBM_ANA_PINS-1:0] analog_conn_o,
    // Peripheral side
    input wire logic fault_enable_i,
    input wire pbm_epwm_t epwm_i,
    input wire logic capcmp_ch2_out_i,
    input wire logic capcmp_ch2_is_output_i,
    output logic ext_irq_in0_o,
    output logic ext_irq_in1_o,
    output logic ext_irq_in2_o,
    output logic pwm_fault_in_o,
    output logic capcmp_ch2_cap_o,
    output logic capcmp_on_portc_pin1_o,
    output logic prog_entry_in_o,
    output logic adc_ch8_in_o,
    output logic adc_ch9_in_o,
    output logic adc_ch10_in_o,
    output logic adc_ch11_in_o,
    output logic adc_ch12_in_o,
    output logic cmp_inv_in_ch2_o,
    output logic cmp_inv_in_ch3_o
);
    logic [PBM_PINS-1:0] pin_s;
    pbm_cfg_t cfg_r;
    pbm_cfg_t cfg_nxt;
    logic cfg_take_r;
    logic cfg_take_nxt;
    logic [5:0] in_data_a_out_latch_r;
    logic [5:0] in_data_a_out_latch_nxt;
    logic [5:0] in_data_a_direction_r;
    logic [5:0] in_data_a_direction_nxt;
    logic [4:0] ansel_r;
    logic [4:0] ansel_nxt;
    logic [5:0] pullup_en_r;
    logic [5:0] pullup_en_nxt;
    logic pullup_all_off_r;
    logic pullup_all_off_nxt;
    logic [7:0] rdata_r;
    logic [7:0] rdata_nxt;
    logic [5:0] eff_dir;
    logic [5:0] in_data_a;
    logic [5:0] dig_in_ok;
    logic [5:0] ana_sel;
    logic pin3_ccp;
    logic pin5_prog;

    pbm_sync u_sync (
        .clk_i(clk_i),
        .reset_i(reset_i),
        .async_i(pin_i),
        .sync_o(pin_s)
    );

    // Register and configuration next state
    always_comb begin
        cfg_take_nxt = 1'b0;
        cfg_nxt = cfg_r;
        if (cfg_take_r) begin
            cfg_nxt = cfg_i;
        end
        in_data_a_out_latch_nxt = in_data_a_out_latch_r;
        in_data_a_direction_nxt = in_data_a_direction_r;
        ansel_nxt = ansel_r;
        pullup_en_nxt = pullup_en_r;
        pullup_all_off_nxt = pullup_all_off_r;
        if (cfg_take_r) begin
            ansel_nxt = cfg_i.analog_default_config ? PBM_ANA_ON : PBM_ANA_OFF;
        end else if (wr_i) begin
            case (addr_i)
                ADDR_LATCH: in_data_a_out_latch_nxt = wdata_i[5:0];
                ADDR_DIR: in_data_a_direction_nxt = wdata_i[5:0];
                ADDR_ANSEL: ansel_nxt = wdata_i[4:0];
                ADDR_PULLUP: begin
                    pullup_en_nxt = wdata_i[5:0];
                    pullup_all_off_nxt = wdata_i[7];
                end
                default: ;
            endcase
        end
        rdata_nxt = 8'h00;
        if (rd_i) begin
            case (addr_i)
                ADDR_LATCH: rdata_nxt = {2'b00, in_data_a_out_latch_r};
                ADDR_DIR: rdata_nxt = {2'b00, in_data_a_direction_r};
                ADDR_ANSEL: rdata_nxt = {3'b000, ansel_r};
                ADDR_PULLUP: rdata_nxt = {pullup_all_off_r, 1'b0, pullup_en_r};
                ADDR_PORT: rdata_nxt = {2'b00, in_data_a};
                ADDR_CFG: rdata_nxt = {4'h0, cfg_r};
                default: rdata_nxt = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            cfg_take_r <= 1'b1;
            cfg_r <= '{capcmp_ch2_pin_select: PBM_CAPCMP_CH2_SEL_RST, default: 1'b0};
            in_data_a_out_latch_r <= PBM_LATCH_RST;
            in_data_a_direction_r <= PBM_DIR_RST;
            ansel_r <= PBM_ANA_ON;
            pullup_en_r <= '0;
            pullup_all_off_r <= 1'b1;
            rdata_r <= 8'h00;
        end else begin
            cfg_take_r <= cfg_take_nxt;
            cfg_r <= cfg_nxt;
            in_data_a_out_latch_r <= in_data_a_out_latch_nxt;
            in_data_a_direction_r <= in_data_a_direction_nxt;
            ansel_r <= ansel_nxt;
            pullup_en_r <= pullup_en_nxt;
            pullup_all_off_r <= pullup_all_off_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    assign rdata_o = rdata_r;

    // Pin function selection
    always_comb begin
        pin3_ccp = (cfg_r.capcmp_ch2_pin_select == PBM_CAPCMP_CH2_ON_PIN3);
        pin5_prog = cfg_r.low_voltage_prog_enable;
        ana_sel = {1'b0, ansel_r};
        eff_dir = in_data_a_direction_r;
        if (pin3_ccp) begin
            eff_dir[PBM_PIN_CAPCMP] = capcmp_ch2_is_output_i ? PBM_DIR_OUT : in_data_a_direction_r[PBM_PIN_CAPCMP];
        end
        if (pin5_prog) begin
            eff_dir[PBM_PIN_PROG] = PBM_DIR_IN;
        end
        pad_o.out = in_data_a_out_latch_r;
        if (cfg_r.package_28pin) begin
            pad_o.out[PBM_PIN_EPWM_B] = epwm_i.epwm_out_b;
            pad_o.out[PBM_PIN_EPWM_C] = epwm_i.epwm_out_c;
            pad_o.out[PBM_PIN_EPWM_D] = epwm_i.epwm_out_d;
        end
        if (pin3_ccp) begin
            pad_o.out[PBM_PIN_CAPCMP] = capcmp_ch2_out_i;
        end
        pad_o.oe = ~eff_dir;
        if (prog_debug_active_i) begin
            pad_o.oe[PBM_PIN_PROG] = 1'b0;
        end
        for (int i = 0; i < PBM_PINS; i++) begin
            dig_in_ok[i] = (eff_dir[i] == PBM_DIR_IN) && !ana_sel[i];
            pad_o.pullup_on[i] = dig_in_ok[i] && pullup_en_r[i] && !pullup_all_off_r;
            in_data_a[i] = dig_in_ok[i] & pin_s[i];
        end
        if (pin5_prog) begin
            pad_o.pullup_on[PBM_PIN_PROG] = 1'b0;
            in_data_a[PBM_PIN_PROG] = 1'b0;
        end
    end

    // Peripheral inputs
    always_comb begin
        ext_irq_in0_o = eff_dir[PBM_PIN_IRQ0] & pin_s[PBM_PIN_IRQ0];
        ext_irq_in1_o = eff_dir[PBM_PIN_IRQ1] & pin_s[PBM_PIN_IRQ1];
        ext_irq_in2_o = eff_dir[PBM_PIN_IRQ2] & pin_s[PBM_PIN_IRQ2];
        pwm_fault_in_o = fault_enable_i & eff_dir[PBM_PIN_FAULT] & pin_s[PBM_PIN_FAULT];
        capcmp_ch2_cap_o = pin3_ccp & eff_dir[PBM_PIN_CAPCMP] & pin_s[PBM_PIN_CAPCMP];
        capcmp_on_portc_pin1_o = !pin3_ccp;
        prog_entry_in_o = pin5_prog & pin_s[PBM_PIN_PROG];
        for (int i = 0; i < PBM_ANA_PINS; i++) begin
            analog_conn_o[i] = ansel_r[i] & eff_dir[i];
        end
        adc_ch12_in_o = analog_conn_o[0];
        adc_ch10_in_o = analog_conn_o[1];
        adc_ch8_in_o = analog_conn_o[2];
        adc_ch9_in_o = analog_conn_o[3];
        adc_ch11_in_o = analog_conn_o[4];
        cmp_inv_in_ch2_o = analog_conn_o[PBM_PIN_CMP_CH2];
        cmp_inv_in_ch3_o = analog_conn_o[PBM_PIN_CMP_CH3];
    end
endmodule // pbm_mux
`default_nettype wire

// [tb/pbm_mux_props.sv]
// Checker for the port B pin function multiplexer
`timescale 1ns/100ps
`default_nettype none
module pbm_mux_props
    import pbm_pkg::*;
(
    // Clock, reset, bus and peripheral inputs
    input wire logic clk_i, reset_i, rd_i, prog_debug_active_i, fault_enable_i,
    input wire logic capcmp_ch2_out_i, capcmp_ch2_is_output_i,
    input wire logic [7:0] rdata_o,
    // Pins and peripheral outputs
    input wire pbm_pad_t pad_o,
    input wire logic [PBM_ANA_PINS-1:0] analog_conn_o,
    input wire logic ext_irq_in0_o, ext_irq_in1_o, ext_irq_in2_o, pwm_fault_in_o, capcmp_on_portc_pin1_o,
    input wire logic adc_ch8_in_o, adc_ch9_in_o, adc_ch10_in_o, adc_ch11_in_o, adc_ch12_in_o,
    input wire logic cmp_inv_in_ch2_o, cmp_inv_in_ch3_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (reset_i);
    a_rdata_slot: assert property (!$past(rd_i) |-> rdata_o == 8'h00)
        else $error("read data outside its slot");
    a_pull_output: assert property ((pad_o.oe & pad_o.pullup_on) == 6'h00)
        else $error("pull-up on an output pin");
    a_pull_analog: assert property ((pad_o.pullup_on[4:0] & analog_conn_o) == 5'h00)
        else $error("pull-up on an analog pin");
    a_adc_map: assert property (
        {adc_ch11_in_o, adc_ch9_in_o, adc_ch8_in_o, adc_ch10_in_o, adc_ch12_in_o} == analog_conn_o)
        else $error("converter channel map wrong");
    a_cmp_map: assert property (
        {cmp_inv_in_ch2_o, cmp_inv_in_ch3_o} == {analog_conn_o[3], analog_conn_o[1]})
        else $error("comparator channel map wrong");
    a_irq_gate: assert property (
        ({ext_irq_in2_o, ext_irq_in1_o, ext_irq_in0_o} & pad_o.oe[2:0]) == 3'h0)
        else $error("interrupt input live on output pin");
    a_fault_gate: assert property (pwm_fault_in_o |-> fault_enable_i && !pad_o.oe[0])
        else $error("fault input live while disabled");
    a_prog_hold: assert property (prog_debug_active_i |-> !pad_o.oe[5])
        else $error("pin 5 driven during debug");
    a_capcmp_drive: assert property (!capcmp_on_portc_pin1_o && capcmp_ch2_is_output_i
        |-> pad_o.oe[3] && pad_o.out[3] == capcmp_ch2_out_i)
        else $error("channel 2 output not on pin 3");
    a_cfg_static: assert property (
        !$past(reset_i) && !$past(reset_i, 2) |-> $stable(capcmp_on_portc_pin1_o))
        else $error("channel 2 routing moved after reset");
    c_analog: cover property (analog_conn_o != 5'h00);
    c_fault: cover property (pwm_fault_in_o);
    c_capcmp: cover property (!capcmp_on_portc_pin1_o && pad_o.oe[3]);
endmodule // pbm_mux_props
`default_nettype wire

// [tb/pbm_pins_model.sv]
// Board-side model of the port B pins
`timescale 1ns/100ps
`default_nettype none
module pbm_pins_model
    import pbm_pkg::*;
(
    // Clock
    input wire logic clk_i,
    // Pad drive and board sources
    input wire pbm_pad_t pad_i,
    input wire logic [5:0] ext_i,
    input wire logic [5:0] ext_en_i,
    // Pin levels
    output logic [5:0] pin_o
);
    logic [5:0] float_r = 6'h15;
    // Undriven pins wander every cycle
    always @(posedge clk_i) begin
        float_r <= ~float_r;
    end
    always_comb begin
        for (int i = 0; i < 6; i++) begin
            pin_o[i] = pad_i.oe[i] ? pad_i.out[i] : ext_en_i[i] ? ext_i[i] : pad_i.pullup_on[i] ? 1'b1 : float_r[i];
        end
    end
endmodule // pbm_pins_model
`default_nettype wire

// [tb/port_b_pin_function_mux_bench.sv]
// Self-checking bench for the port B pin function multiplexer
`timescale 1ns/100ps
`default_nettype none
module port_b_pin_function_mux_bench
    import pbm_pkg::*;
;
    logic clk_i = 0, reset_i = 1, wr_i = 0, rd_i = 0, prog_debug_active_i = 0, fault_enable_i = 0;
    logic capcmp_ch2_out_i = 0, capcmp_ch2_is_output_i = 0;
    logic [3:0] addr_i = 4'h0;
    logic [7:0] wdata_i = 8'h00, rdata_o;
    logic [5:0] pin_i, ext_i = 6'h00, ext_en_i = 6'h00, dir, lat;
    logic [4:0] analog_conn_o, ana;
    logic pu;
    pbm_cfg_t cfg_i = 4'hC;
    pbm_epwm_t epwm_i = 3'h0;
    pbm_pad_t pad_o;
    logic ext_irq_in0_o, ext_irq_in1_o, ext_irq_in2_o, pwm_fault_in_o, capcmp_ch2_cap_o;
    logic capcmp_on_portc_pin1_o, prog_entry_in_o, cmp_inv_in_ch2_o, cmp_inv_in_ch3_o;
    logic adc_ch8_in_o, adc_ch9_in_o, adc_ch10_in_o, adc_ch11_in_o, adc_ch12_in_o;
    int mismatches = 0, checks_done = 0;
    pbm_mux u_pbm_mux (.*);
    pbm_pins_model u_pbm_pins_model (.clk_i, .pad_i(pad_o), .ext_i, .ext_en_i, .pin_o(pin_i));
    always #5 clk_i = ~clk_i;
    function automatic logic [7:0] f_port(logic [5:0] d, logic [5:0] e, logic [4:0] a);
        return {2'h0, d & e & ~{1'b0, a}};
    endfunction
    function automatic logic [7:0] f_pull(logic [5:0] d, logic [4:0] a);
        return {2'h0, d & ~{1'b0, a}};
    endfunction
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] %0t got %h want %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge clk_i);
        wr_i <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [7:0] exp);
        @(posedge clk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge clk_i);
        rd_i <= 1'b0;
        #1 chk(rdata_o, exp);
    endtask
    task automatic do_reset(input pbm_cfg_t c);
        cfg_i <= c;
        reset_i <= 1'b1;
        repeat (16) @(posedge clk_i);
        reset_i <= 1'b0;
        repeat (2) @(posedge clk_i);
    endtask
    task automatic conclude();
        $display("checks_done %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    initial begin
        #100000;
        mismatches++;
        conclude();
    end
    initial begin
        void'($urandom(30613));
        do_reset(4'hC);
        rd(4'h0, 8'h00);
        rd(4'h1, 8'h3F);
        rd(4'h2, 8'h1F);
        rd(4'h3, 8'h80);
        rd(4'hF, 8'h00);
        chk({3'h0, analog_conn_o}, 8'h1F);
        chk({7'h0, capcmp_on_portc_pin1_o}, 8'h01);
        $display("test reset done");
        for (int i = 0; i < 10; i++) begin
            @(posedge clk_i);
            lat = 6'($urandom);
            dir = 6'($urandom);
            ana = (i < 4) ? 5'h00 : 5'($urandom);
            pu = (i < 2) ? 1'b0 : 1'($urandom);
            ext_i <= 6'($urandom);
            ext_en_i <= dir;
            fault_enable_i <= 1'($urandom);
            prog_debug_active_i <= (i < 2) ? 1'b0 : 1'($urandom);
            wr(4'h0, {2'h0, lat});
            wr(4'h1, {2'h0, dir});
            wr(4'h2, {3'h0, ana});
            wr(4'h3, {pu, 7'h3F});
            repeat (3) @(posedge clk_i);
            rd(4'h1, {2'h0, dir});
            rd(4'h4, f_port(dir, ext_i, ana));
            chk({2'h0, pad_o.oe}, {2'h0, ~dir & {~prog_debug_active_i, 5'h1F}});
            chk({2'h0, pad_o.out & ~dir}, {2'h0, lat & ~dir});
            chk({3'h0, analog_conn_o}, {3'h0, ana & dir[4:0]});
            chk({2'h0, pad_o.pullup_on}, f_pull(dir, ana) & {2'h0, {6{~pu}}});
            chk({5'h0, ext_irq_in2_o, ext_irq_in1_o, ext_irq_in0_o}, {5'h0, dir[2:0] & ext_i[2:0]});
            chk({7'h0, pwm_fault_in_o}, {7'h0, fault_enable_i & dir[0] & ext_i[0]});
            chk({3'h0, adc_ch11_in_o, adc_ch9_in_o, adc_ch8_in_o, adc_ch10_in_o, adc_ch12_in_o},
                {3'h0, ana & dir[4:0]});
            chk({6'h0, cmp_inv_in_ch2_o, cmp_inv_in_ch3_o}, {6'h0, ana[3] & dir[3], ana[1] & dir[1]});
        end
        $display("test random done");
        do_reset(4'h3);
        chk({3'h0, analog_conn_o}, 8'h00);
        chk({7'h0, capcmp_on_portc_pin1_o}, 8'h00);
        wr(4'h5, 8'hFF);
        rd(4'h5, 8'h03);
        epwm_i <= 3'h5;
        capcmp_ch2_is_output_i <= 1'b1;
        capcmp_ch2_out_i <= 1'b1;
        prog_debug_active_i <= 1'b1;
        ext_i <= 6'h28;
        ext_en_i <= 6'h20;
        wr(4'h1, 8'h00);
        repeat (3) @(posedge clk_i);
        chk({2'h0, pad_o.oe}, 8'h1F);
        chk({3'h0, pad_o.out[4:0]}, 8'h1C);
        chk({7'h0, prog_entry_in_o}, 8'h01);
        capcmp_ch2_is_output_i <= 1'b0;
        ext_en_i <= 6'h28;
        wr(4'h1, 8'h08);
        repeat (3) @(posedge clk_i);
        chk({7'h0, capcmp_ch2_cap_o}, 8'h01);
        $display("test alternate done");
        conclude();
    end
endmodule // port_b_pin_function_mux_bench
bind pbm_mux pbm_mux_props u_pbm_mux_props (.*);
`default_nettype wire
